/* File: rtl/rtc_top.sv */
// Tick timer and clock watch with an APB register slave.
// Assumes low_speed_clk and one_hertz_tick are asynchronous pins; everything else is on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_params.svh"

// What this block does
// - 32-bit down-counter steps on low-speed ticks, interrupts on reaching zero.
// - One-shot select 0 gives periodic reload; the interrupt interval follows the reload values chosen by the pattern.
// - One-shot select 1 interrupts once, halts; restart by run-enable or first reload write.
// - Periodic reload takes first value on pattern bit 0, second on 1.
// - Steps through 128-bit pattern; length comes from control bits 10 to 4.
// - Reload register writes are ignored while the counter runs.
// - Halted reload writes are taken; self-start mode then sets run-enable.
// - Counter steps once per low-speed clock period, 31.25 us on average.
// - Low-power mode stops timer and calendar; no wake-up source.
// - Seconds and minutes count 0 to 59, hours 0 to 23.
// - Day of week counts 1 to 7, month 1 to 12.
// - Day of month limit follows month length and leap year.
// - Seconds advance on each one-hertz tick that does not take a pending load.
// - Year held in its own count register.
// - Load registers copied into counters at the next one-hertz rising edge after a date load write.
// - After each increment, compare counts with match registers; equal raises alarm.
// - Combined interrupt output is OR of alarm and timer interrupts.
// - Per-interrupt mask; raw and masked status both readable.
// - Pending interrupt stays until software writes 1 to its clear bit.
module rtc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic low_power,
	input wire logic low_speed_clk,
	input wire logic one_hertz_tick,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`RTC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic watch_alarm_irq,
	output logic timer_zero_irq,
	output logic combined_irq
);
	import rtc_pkg::*;

	// Pin synchronisers: bit 0 low-speed clock, bit 1 one-hertz tick
	logic [1:0] pin_in;
	logic [1:0] sync_a;
	logic [1:0] sync_b;
	logic [1:0] sync_c;
	logic ls_edge;
	logic hz_edge;

	assign pin_in = {one_hertz_tick, low_speed_clk};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
					sync_c[gi] <= 1'b0;
				end else if (clk_en) begin
					sync_a[gi] <= pin_in[gi];
					sync_b[gi] <= sync_a[gi];
					sync_c[gi] <= sync_b[gi];
				end
			end
		end
	endgenerate

	assign ls_edge = sync_b[0] && !sync_c[0] && !low_power;
	assign hz_edge = sync_b[1] && !sync_c[1] && !low_power;

	// APB handshake
	rtc_bus_e bus_state;
	logic bus_wr;
	logic [31:0] next_prdata;
	logic next_slverr;
	logic addr_hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_state <= RTC_BUS_IDLE;
		end else if (clk_en) begin
			case (bus_state)
				RTC_BUS_IDLE: bus_state <= (psel && penable) ? RTC_BUS_WAIT : RTC_BUS_IDLE;
				RTC_BUS_WAIT: bus_state <= RTC_BUS_DONE;
				RTC_BUS_DONE: bus_state <= RTC_BUS_IDLE;
				default: bus_state <= RTC_BUS_IDLE;
			endcase
		end
	end

	assign bus_wr = psel && penable && pwrite && pready && !pslverr;

	// Registers
	rtc_date_s dt_match;
	rtc_date_s dt_load;
	rtc_year_t yr_match;
	rtc_year_t yr_load;
	rtc_date_s dt_count;
	rtc_year_t yr_count;
	logic [1:0] irq_mask;
	logic [1:0] raw_irq;
	logic [31:0] first_reload_value;
	logic [31:0] second_reload_value;
	logic [127:0] pattern;
	logic [31:0] count;
	logic [31:0] irq_number;
	logic [6:0] pat_idx;
	logic timer_run_enable;
	logic timer_one_shot_select;
	logic self_start;
	logic [6:0] pat_len;
	logic [10:0] ctrl_pend;
	logic ctrl_pend_vld;
	logic start_req;
	logic dt_load_pend;
	logic cmp_pend;
	logic alarm_evt;
	logic timer_evt;
	logic wr_tlr1;
	logic wr_tlr2;

	assign wr_tlr1 = bus_wr && (paddr == `RTC_OFS_RLD1) && !timer_run_enable;
	assign wr_tlr2 = bus_wr && (paddr == `RTC_OFS_RLD2) && !timer_run_enable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dt_match <= '0;
			dt_load <= '0;
			yr_match <= `RTC_YMATCH_RST;
			yr_load <= '0;
			irq_mask <= 2'h0;
			pattern <= '0;
		end else if (clk_en && bus_wr) begin
			case (paddr)
				`RTC_OFS_DMATCH: dt_match <= rtc_date_s'(pwdata[28:0]);
				`RTC_OFS_DLOAD: dt_load <= rtc_date_s'(pwdata[28:0]);
				`RTC_OFS_YMATCH: yr_match <= pwdata[13:0];
				`RTC_OFS_YLOAD: yr_load <= pwdata[13:0];
				`RTC_OFS_MASK: irq_mask <= pwdata[1:0];
				default: begin
					for (int k = 0; k < 4; k++) begin
						if (paddr == `RTC_OFS_TPR1 + 12'(4 * k)) begin
							pattern[32*k +: 32] <= pwdata;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_reload_value <= '0;
			second_reload_value <= '0;
		end else if (clk_en) begin
			if (wr_tlr1) begin
				first_reload_value <= pwdata;
			end
			if (wr_tlr2) begin
				second_reload_value <= pwdata;
			end
		end
	end

	// Tick timer; requests from the bus wait for the next low-speed tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= `RTC_TDR_RST;
			pat_idx <= '0;
			irq_number <= '0;
			timer_run_enable <= 1'b0;
			timer_one_shot_select <= 1'b0;
			self_start <= 1'b0;
			pat_len <= '0;
			ctrl_pend <= '0;
			ctrl_pend_vld <= 1'b0;
			start_req <= 1'b0;
			timer_evt <= 1'b0;
		end else if (clk_en) begin
			timer_evt <= 1'b0;
			if (ls_edge) begin
				ctrl_pend_vld <= 1'b0;
				start_req <= 1'b0;
				if (ctrl_pend_vld) begin
					timer_run_enable <= ctrl_pend[`RTC_CTRL_RUN];
					timer_one_shot_select <= ctrl_pend[`RTC_CTRL_ONESHOT];
					self_start <= ctrl_pend[`RTC_CTRL_SELFSTART];
					pat_len <= ctrl_pend[`RTC_CTRL_LEN_HI:`RTC_CTRL_LEN_LO];
					if (ctrl_pend[`RTC_CTRL_RUN] && !timer_run_enable) begin
						count <= first_reload_value;
						pat_idx <= '0;
					end
				end else if (start_req) begin
					timer_run_enable <= 1'b1;
					count <= first_reload_value;
					pat_idx <= '0;
				end else if (timer_run_enable) begin
					if (count == 32'h0) begin
						timer_evt <= 1'b1;
						irq_number <= irq_number + 32'd1;
						if (timer_one_shot_select) begin
							timer_run_enable <= 1'b0;
						end else begin
							count <= pattern[pat_idx] ? second_reload_value : first_reload_value;
							pat_idx <= (pat_idx == pat_len) ? 7'd0 : pat_idx + 7'd1;
						end
					end else begin
						count <= count - 32'd1;
					end
				end
			end
			if (bus_wr && paddr == `RTC_OFS_CTRL) begin
				ctrl_pend <= pwdata[10:0];
				ctrl_pend_vld <= 1'b1;
			end
			if ((wr_tlr1 && (timer_one_shot_select || self_start)) || (wr_tlr2 && self_start)) begin
				start_req <= 1'b1;
			end
		end
	end

	// Clock watch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dt_load_pend <= 1'b0;
			cmp_pend <= 1'b0;
		end else if (clk_en) begin
			cmp_pend <= hz_edge && !dt_load_pend;
			if (hz_edge) begin
				dt_load_pend <= 1'b0;
			end
			if (bus_wr && paddr == `RTC_OFS_DLOAD) begin
				dt_load_pend <= 1'b1;
			end
		end
	end

	rtc_calendar u_calendar (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.step(hz_edge && !dt_load_pend),
		.load(hz_edge && dt_load_pend),
		.load_date(dt_load),
		.load_year(yr_load),
		.date(dt_count),
		.year(yr_count)
	);

	// Zero in a match field other than the time of day matches anything
	always_comb begin
		alarm_evt = cmp_pend
			&& dt_count.second == dt_match.second
			&& dt_count.minute == dt_match.minute
			&& dt_count.hour == dt_match.hour
			&& (dt_match.day_of_week == 3'd0 || dt_count.day_of_week == dt_match.day_of_week)
			&& (dt_match.day_of_month == 5'd0 || dt_count.day_of_month == dt_match.day_of_month)
			&& (dt_match.month == 4'd0 || dt_count.month == dt_match.month)
			&& (yr_match == 14'd0 || yr_count == yr_match);
	end

	// Interrupt status: a new event wins over a clear in the same cycle
	logic [1:0] irq_clr;
	logic [1:0] irq_set;
	logic [1:0] next_raw;

	assign irq_clr = (bus_wr && paddr == `RTC_OFS_CLEAR) ? pwdata[1:0] : 2'h0;
	assign irq_set = {timer_evt, alarm_evt};
	assign next_raw = (raw_irq & ~irq_clr) | irq_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_irq <= 2'h0;
			watch_alarm_irq <= 1'b0;
			timer_zero_irq <= 1'b0;
			combined_irq <= 1'b0;
		end else if (clk_en) begin
			raw_irq <= next_raw;
			watch_alarm_irq <= next_raw[`RTC_IRQ_ALARM] && irq_mask[`RTC_IRQ_ALARM];
			timer_zero_irq <= next_raw[`RTC_IRQ_TIMER] && irq_mask[`RTC_IRQ_TIMER];
			combined_irq <= |(next_raw & irq_mask);
		end
	end

	// Read mux
	always_comb begin
		next_prdata = 32'h0;
		addr_hit = 1'b1;
		case (paddr)
			`RTC_OFS_DATE: next_prdata = {3'h0, dt_count};
			`RTC_OFS_DMATCH: next_prdata = {3'h0, dt_match};
			`RTC_OFS_DLOAD: next_prdata = {3'h0, dt_load};
			`RTC_OFS_YEAR: next_prdata = {18'h0, yr_count};
			`RTC_OFS_YMATCH: next_prdata = {18'h0, yr_match};
			`RTC_OFS_YLOAD: next_prdata = {18'h0, yr_load};
			`RTC_OFS_MASK: next_prdata = {30'h0, irq_mask};
			`RTC_OFS_RIS: next_prdata = {30'h0, raw_irq};
			`RTC_OFS_MIS: next_prdata = {30'h0, raw_irq & irq_mask};
			`RTC_OFS_CLEAR: next_prdata = 32'h0;
			`RTC_OFS_TDR: next_prdata = count;
			`RTC_OFS_CTRL: next_prdata = {21'h0, pat_len, 1'b0, self_start, timer_one_shot_select, timer_run_enable};
			`RTC_OFS_RLD1: next_prdata = first_reload_value;
			`RTC_OFS_RLD2: next_prdata = second_reload_value;
			`RTC_OFS_TIN: next_prdata = irq_number;
			default: begin
				addr_hit = 1'b0;
				for (int k = 0; k < 4; k++) begin
					if (paddr == `RTC_OFS_TPR1 + 12'(4 * k)) begin
						next_prdata = pattern[32*k +: 32];
						addr_hit = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (clk_en) begin
			pready <= (bus_state == RTC_BUS_WAIT);
			pslverr <= (bus_state == RTC_BUS_WAIT) && !addr_hit;
			if (bus_state == RTC_BUS_WAIT && !pwrite) begin
				prdata <= next_prdata;
			end
		end
	end

endmodule // rtc_top

`default_nettype wire

/* File: rtl/rtc_params.svh */
// Register offsets, field positions and reset values of the timer and clock watch.
// Assumes a 32-bit APB slave decoding byte addresses on paddr[11:0].
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

`define RTC_ADDR_W 12
`define RTC_OFS_DATE 12'h000
`define RTC_OFS_DMATCH 12'h004
`define RTC_OFS_DLOAD 12'h008
`define RTC_OFS_YEAR 12'h00c
`define RTC_OFS_YMATCH 12'h010
`define RTC_OFS_YLOAD 12'h014
`define RTC_OFS_MASK 12'h01c
`define RTC_OFS_RIS 12'h020
`define RTC_OFS_MIS 12'h024
`define RTC_OFS_CLEAR 12'h028
`define RTC_OFS_TDR 12'h02c
`define RTC_OFS_CTRL 12'h030
`define RTC_OFS_RLD1 12'h034
`define RTC_OFS_RLD2 12'h038
`define RTC_OFS_TPR1 12'h03c
`define RTC_OFS_TPR4 12'h048
`define RTC_OFS_TIN 12'h04c

`define RTC_DATE_RST 29'h02120000
`define RTC_YEAR_RST 14'h2000
`define RTC_YMATCH_RST 14'h2000
`define RTC_TDR_RST 32'h0fffffff

// Timer control fields
`define RTC_CTRL_RUN 0
`define RTC_CTRL_ONESHOT 1
`define RTC_CTRL_SELFSTART 2
`define RTC_CTRL_LEN_LO 4
`define RTC_CTRL_LEN_HI 10

// Interrupt bit positions in mask, raw, masked and clear registers
`define RTC_IRQ_ALARM 0
`define RTC_IRQ_TIMER 1

// Calendar limits
`define RTC_SEC_MAX 6'h3b
`define RTC_MIN_MAX 6'h3b
`define RTC_HOUR_MAX 5'h17
`define RTC_DAYW_MAX 3'h7
`define RTC_MONTH_MAX 4'hc

`endif

/* File: rtl/rtc_pkg.sv */
// Types shared by the timer and clock watch design files.
// Assumes rtc_params.svh supplies the numeric constants.
`default_nettype none
package rtc_pkg;

	// Date and time count, laid out as in the date/time registers
	typedef struct packed {
		logic [3:0] month;
		logic [4:0] day_of_month;
		logic [2:0] day_of_week;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} rtc_date_s;

	typedef logic [13:0] rtc_year_t;

	typedef enum logic [1:0] {
		RTC_BUS_IDLE = 2'b00,
		RTC_BUS_WAIT = 2'b01,
		RTC_BUS_DONE = 2'b11
	} rtc_bus_e;

endpackage

`default_nettype wire

/* File: rtl/rtc_calendar.sv */
// Calendar counters: seconds through months plus year, with load and step.
// Assumes step and load are single-cycle pulses on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_params.svh"

module rtc_calendar (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic step,
	input wire logic load,
	input wire rtc_pkg::rtc_date_s load_date,
	input wire rtc_pkg::rtc_year_t load_year,
	output rtc_pkg::rtc_date_s date,
	output rtc_pkg::rtc_year_t year
);
	import rtc_pkg::*;

	rtc_date_s next_date;
	rtc_year_t next_year;
	logic leap;
	logic [4:0] month_days;

	always_comb begin
		leap = (year % 14'd4 == 14'd0) && ((year % 14'd100 != 14'd0) || (year % 14'd400 == 14'd0));
		case (date.month)
			4'h2: month_days = leap ? 5'd29 : 5'd28;
			4'h4, 4'h6, 4'h9, 4'hb: month_days = 5'd30;
			default: month_days = 5'd31;
		endcase
	end

	// Rollover cascade from seconds up to year
	always_comb begin
		next_date = date;
		next_year = year;
		if (date.second != `RTC_SEC_MAX) begin
			next_date.second = date.second + 6'd1;
		end else begin
			next_date.second = 6'd0;
			if (date.minute != `RTC_MIN_MAX) begin
				next_date.minute = date.minute + 6'd1;
			end else begin
				next_date.minute = 6'd0;
				if (date.hour != `RTC_HOUR_MAX) begin
					next_date.hour = date.hour + 5'd1;
				end else begin
					next_date.hour = 5'd0;
					next_date.day_of_week = (date.day_of_week == `RTC_DAYW_MAX) ? 3'd1 :
						date.day_of_week + 3'd1;
					if (date.day_of_month < month_days) begin
						next_date.day_of_month = date.day_of_month + 5'd1;
					end else begin
						next_date.day_of_month = 5'd1;
						if (date.month != `RTC_MONTH_MAX) begin
							next_date.month = date.month + 4'd1;
						end else begin
							next_date.month = 4'd1;
							next_year = year + 14'd1;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			date <= rtc_date_s'(`RTC_DATE_RST);
			year <= `RTC_YEAR_RST;
		end else if (clk_en) begin
			if (load) begin
				date <= load_date;
				year <= load_year;
			end else if (step) begin
				date <= next_date;
				year <= next_year;
			end
		end
	end

endmodule // rtc_calendar

`default_nettype wire

/* File: dv/rtc_top_chk.sv */
// Checker for the timer and clock watch: bus answer timing and interrupt outputs.
// Assumes it is bound to rtc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_params.svh"
module rtc_top_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic low_speed_clk,
	input wire logic one_hertz_tick,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`RTC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic watch_alarm_irq,
	input wire logic timer_zero_irq,
	input wire logic combined_irq
);
	logic ls_q, hz_q;
	logic [1:0] mk;
	logic [4:0] ls_age, hz_age, wr_age;
	wire wr_done = psel && penable && pready && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Cycles since slow-pin rises and since the last mask or clear write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ls_q <= 1'b0;
			hz_q <= 1'b0;
			mk <= 2'h0;
			ls_age <= 5'h1f;
			hz_age <= 5'h1f;
			wr_age <= 5'h1f;
		end else begin
			ls_q <= low_speed_clk;
			hz_q <= one_hertz_tick;
			ls_age <= (low_speed_clk && !ls_q) ? 5'h00 : ls_age + {4'h0, ls_age != 5'h1f};
			hz_age <= (one_hertz_tick && !hz_q) ? 5'h00 : hz_age + {4'h0, hz_age != 5'h1f};
			wr_age <= (wr_done && (paddr == 12'h01c || paddr == 12'h028)) ? 5'h00 : wr_age + {4'h0, wr_age != 5'h1f};
			if (wr_done && paddr == 12'h01c)
				mk <= pwdata[1:0];
		end
	end
	sequence s_ans;
		!pready ##1 !pready ##1 pready ##1 !pready;
	endsequence
	property p_ans; psel && penable && !$past(penable) |-> s_ans; endproperty
	property p_rd; $changed(prdata) |-> pready; endproperty
	property p_comb; combined_irq == (watch_alarm_irq || timer_zero_irq); endproperty
	property p_tfall; $fell(timer_zero_irq) |-> wr_age < 5'h04; endproperty
	property p_afall; $fell(watch_alarm_irq) |-> wr_age < 5'h04; endproperty
	property p_trise; $rose(timer_zero_irq) |-> ls_age < 5'h10 || wr_age < 5'h04; endproperty
	property p_arise; $rose(watch_alarm_irq) |-> hz_age < 5'h10 || wr_age < 5'h04; endproperty
	property p_tmask; !mk[1] && !$past(mk[1]) |-> !timer_zero_irq; endproperty
	property p_amask; !mk[0] && !$past(mk[0]) |-> !watch_alarm_irq; endproperty
	a_ans: assert property (p_ans) else $error("bus answer not on third access edge");
	a_rd: assert property (p_rd) else $error("read data moved without answer");
	a_comb: assert property (p_comb) else $error("combined irq not or of both");
	a_tfall: assert property (p_tfall) else $error("timer irq dropped without clear");
	a_afall: assert property (p_afall) else $error("alarm irq dropped without clear");
	a_trise: assert property (p_trise) else $error("timer irq without slow tick");
	a_arise: assert property (p_arise) else $error("alarm irq without one hertz tick");
	a_tmask: assert property (p_tmask) else $error("masked timer irq seen");
	a_amask: assert property (p_amask) else $error("masked alarm irq seen");
endmodule // rtc_top_chk

bind rtc_top rtc_top_chk u_chk (.pclk(pclk), .presetn(presetn), .low_speed_clk(low_speed_clk),
	.one_hertz_tick(one_hertz_tick), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .watch_alarm_irq(watch_alarm_irq),
	.timer_zero_irq(timer_zero_irq), .combined_irq(combined_irq));
`default_nettype wire

/* File: dv/test_rtc_timer_and_clock_watch.sv */
// Self-checking bench for the timer and clock watch over APB.
// Assumes rtc_top; slow pins are pulsed by hand, far faster than real.
`timescale 1ns/1ps
`default_nettype none
module test_rtc_timer_and_clock_watch;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic low_power = 1'b0;
	logic clk_en = 1'b1;
	logic low_speed_clk = 1'b0;
	logic one_hertz_tick = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
	logic watch_alarm_irq, timer_zero_irq, combined_irq;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	int errors = 0, n_checks = 0;
	logic [11:0] ra [5] = '{12'h000, 12'h00c, 12'h010, 12'h02c, 12'h030};
	logic [31:0] rv [5] = '{32'h02120000, 32'h2000, 32'h2000, 32'h0fffffff, 32'h0};
	logic [31:0] pe [11] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h3, 32'h2, 32'h1, 32'h0, 32'h1, 32'h0, 32'h3};
	logic [31:0] os [5] = '{32'h2, 32'h1, 32'h0, 32'h0, 32'h0};
	logic [31:0] rs [3] = '{32'h1, 32'h0, 32'h0};
	logic [31:0] ld [3], ly [3], ed [3], ey [3];

	always #2.5 pclk = ~pclk;

	rtc_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .low_power(low_power),
		.low_speed_clk(low_speed_clk), .one_hertz_tick(one_hertz_tick), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .watch_alarm_irq(watch_alarm_irq), .timer_zero_irq(timer_zero_irq),
		.combined_irq(combined_irq));

	function automatic logic [31:0] dt(input int mo, dm, dw, h, mi, s);
		return {3'h0, mo[3:0], dm[4:0], dw[2:0], h[4:0], mi[5:0], s[5:0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			errors++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask

	// One slow-pin period: 10 cycles high, 10 low
	task automatic pulse(input logic hz);
		if (hz)
			one_hertz_tick <= 1'b1;
		else
			low_speed_clk <= 1'b1;
		repeat (10) @(posedge pclk);
		one_hertz_tick <= 1'b0;
		low_speed_clk <= 1'b0;
		repeat (10) @(posedge pclk);
	endtask

	task automatic tk(input logic [31:0] x);
		pulse(1'b0);
		rd(12'h02c, x);
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#50000;
		errors++;
		summarize();
	end

	initial begin
		ld = '{dt(2, 28, 7, 23, 59, 59), dt(2, 28, 3, 23, 59, 59), dt(12, 31, 1, 23, 59, 59)};
		ed = '{dt(3, 1, 1, 0, 0, 0), dt(2, 29, 4, 0, 0, 0), dt(1, 1, 2, 0, 0, 0)};
		ly = '{32'h7e7, 32'h7e8, 32'h7e7};
		ey = '{32'h7e7, 32'h7e8, 32'h7e8};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (ra[i]) rd(ra[i], rv[i]);
		apb(1'b0, 12'h018, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(12'h01c, 32'h3);
		wr(12'h034, 32'h1);
		wr(12'h038, 32'h3);
		wr(12'h03c, 32'h6);
		wr(12'h030, 32'h11);
		foreach (pe[i]) tk(pe[i]);
		rd(12'h04c, 32'h4);
		chk({30'h0, timer_zero_irq, combined_irq}, 32'h3);
		wr(12'h034, 32'h55);
		rd(12'h034, 32'h1);
		wr(12'h030, 32'h0);
		repeat (3) pulse(1'b0);
		rd(12'h030, 32'h0);
		wr(12'h038, 32'h5);
		rd(12'h038, 32'h5);
		wr(12'h028, 32'h2);
		repeat (3) @(posedge pclk);
		chk({31'h0, timer_zero_irq}, 32'h0);
		wr(12'h034, 32'h2);
		wr(12'h030, 32'h3);
		foreach (os[i]) tk(os[i]);
		rd(12'h030, 32'h2);
		wr(12'h034, 32'h1);
		foreach (rs[i]) tk(rs[i]);
		rd(12'h04c, 32'h6);
		// Self-start: halted reload write starts the timer
		wr(12'h030, 32'h6);
		pulse(1'b0);
		wr(12'h038, 32'h1);
		tk(32'h1);
		rd(12'h030, 32'h7);
		wr(12'h01c, 32'h1);
		repeat (3) @(posedge pclk);
		chk({31'h0, timer_zero_irq}, 32'h0);
		rd(12'h020, 32'h2);
		rd(12'h024, 32'h0);
		wr(12'h028, 32'h2);
		wr(12'h004, dt(1, 1, 2, 0, 0, 0));
		wr(12'h010, 32'h7e8);
		for (int i = 0; i < 3; i++) begin
			wr(12'h008, ld[i]);
			wr(12'h014, ly[i]);
			pulse(1'b1);
			rd(12'h000, ld[i]);
			rd(12'h00c, ly[i]);
			pulse(1'b1);
			rd(12'h000, ed[i]);
			rd(12'h00c, ey[i]);
		end
		chk({30'h0, watch_alarm_irq, combined_irq}, 32'h3);
		low_power <= 1'b1;
		pulse(1'b1);
		rd(12'h000, dt(1, 1, 2, 0, 0, 0));
		low_power <= 1'b0;
		// Clock enable low freezes the calendar through a tick
		clk_en <= 1'b0;
		pulse(1'b1);
		clk_en <= 1'b1;
		rd(12'h000, dt(1, 1, 2, 0, 0, 0));
		wr(12'h028, 32'h1);
		repeat (3) @(posedge pclk);
		chk({30'h0, watch_alarm_irq, combined_irq}, 32'h0);
		summarize();
	end
endmodule // test_rtc_timer_and_clock_watch
`default_nettype wire
